// ---- rtl/i2cs_pkg.sv ----
// package: status codes, state and role types of the addressed slave
// assumes: shared by the bus sampler, the slave core and the testbench
package i2cs_pkg;

    // synchroniser depth for pin inputs
    localparam int SYNC_DEPTH = 3;
    // bits in an address or data byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_FALL = 4'h7;
    localparam logic [6:0] GC_ADDR = 7'h00;

    // status codes
    localparam logic [7:0] ST_NONE = 8'hF8;
    localparam logic [7:0] ST_60 = 8'h60;
    localparam logic [7:0] ST_68 = 8'h68;
    localparam logic [7:0] ST_70 = 8'h70;
    localparam logic [7:0] ST_78 = 8'h78;
    localparam logic [7:0] ST_80 = 8'h80;
    localparam logic [7:0] ST_88 = 8'h88;
    localparam logic [7:0] ST_90 = 8'h90;
    localparam logic [7:0] ST_98 = 8'h98;
    localparam logic [7:0] ST_A0 = 8'hA0;
    localparam logic [7:0] ST_A8 = 8'hA8;
    localparam logic [7:0] ST_B0 = 8'hB0;
    localparam logic [7:0] ST_B8 = 8'hB8;
    localparam logic [7:0] ST_C0 = 8'hC0;
    localparam logic [7:0] ST_C8 = 8'hC8;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_HOLD,
        S_RX,
        S_RX_ACK,
        S_TX,
        S_TX_ACK
    } i2cs_state_t;

    typedef enum logic [1:0] {
        ROLE_RX_OWN,
        ROLE_RX_GC,
        ROLE_TX
    } i2cs_role_t;

endpackage : i2cs_pkg

// ---- rtl/i2cs_link_if.sv ----
// interface: sampled bus levels and events from sampler to slave core
// assumes: both ends on mclk_i
`timescale 1ns/1ns
`default_nettype none

interface i2cs_link_if;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic busy;

    modport samp (output scl, sda, rise, fall, start, stop, busy);
    modport core (input scl, sda, rise, fall, start, stop, busy);
endinterface : i2cs_link_if

`default_nettype wire

// ---- rtl/i2cs_sampler.sv ----
// module: three-stage sampling of the bus pins, edge and start/stop events
// assumes: scl_i and sda_i are asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none

module i2cs_sampler
    import i2cs_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    // sampled events
    i2cs_link_if.samp lk
);

    typedef struct packed {
        logic [SYNC_DEPTH-1:0] scl_sh;
        logic [SYNC_DEPTH-1:0] sda_sh;
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic busy;
    } i2cs_samp_t;

    i2cs_samp_t q;
    i2cs_samp_t next_q;

    always_comb
    begin
        next_q = q;
        next_q.scl_sh = {q.scl_sh[SYNC_DEPTH-2:0], scl_i};
        next_q.sda_sh = {q.sda_sh[SYNC_DEPTH-2:0], sda_i};
        // change counts once second and third stage agree
        if (q.scl_sh[1] == q.scl_sh[2])
        begin
            next_q.scl = q.scl_sh[1];
        end
        if (q.sda_sh[1] == q.sda_sh[2])
        begin
            next_q.sda = q.sda_sh[1];
        end
        next_q.rise = !q.scl && next_q.scl;
        next_q.fall = q.scl && !next_q.scl;
        next_q.start = q.scl && next_q.scl && q.sda && !next_q.sda;
        next_q.stop = q.scl && next_q.scl && !q.sda && next_q.sda;
        if (next_q.start)
        begin
            next_q.busy = 1'b1;
        end
        else if (next_q.stop)
        begin
            next_q.busy = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q <= '{scl_sh: 3'h7, sda_sh: 3'h7, scl: 1'b1, sda: 1'b1, default: 1'b0};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign lk.scl = q.scl;
    assign lk.sda = q.sda;
    assign lk.rise = q.rise;
    assign lk.fall = q.fall;
    assign lk.start = q.start;
    assign lk.stop = q.stop;
    assign lk.busy = q.busy;

endmodule : i2cs_sampler

`default_nettype wire

// ---- rtl/i2cs_slave.sv ----
// module: addressed slave of a two-wire bus, receive end states and transmit
// assumes: open-drain pins resolved outside; software handshakes via si_clear_i
//
// Overview of operation
// - general-call byte NACKed gives flag, 0x98
// - leaving end state, ack clear: not addressed
// - ack set: own address, general call if enabled
// - start request waits for free bus
// - stay idle until own address seen
// - transmit only on read bit of one
// - own address with read sets flag, status
// - lost arbitration then read gives 0xB0
// - ack cleared: last byte, then 0xC0/0xC8
// - after last byte release data line
// - ack clear ignores addresses, setting re-enables
// - own read acknowledged gives 0xA8, loads byte
// - transmitted byte acknowledged gives 0xB8
`timescale 1ns/1ns
`default_nettype none

module i2cs_slave
    import i2cs_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // bus pins, open drain, enables low while driving
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // configuration
    input wire logic [6:0] own_bus_addr_i,
    input wire logic gc_enable_i,
    // ctrl_flags
    input wire logic ack_assert_i,
    input wire logic begin_request_bit_i,
    input wire logic si_clear_i,
    input wire logic arb_lost_i,
    // byte_buffer and status
    input wire logic [7:0] byte_buffer_i,
    output logic [7:0] byte_buffer_o,
    output logic [7:0] status_o,
    output logic si_o,
    output logic master_start_o
);

    typedef struct packed {
        i2cs_state_t state;
        i2cs_role_t role;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [7:0] status;
        logic [7:0] rx_byte;
        logic si;
        logic sda_low;
        logic ack_plan;
        logic last;
        logic nack;
        logic restart;
        logic start_pend;
        logic mstart;
    } i2cs_core_t;

    i2cs_core_t q;
    i2cs_core_t next_q;
    logic addressed;

    i2cs_link_if lk ();

    i2cs_sampler u_sampler (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lk(lk)
    );

    // general call: address zero with write direction
    function automatic logic is_gc(input logic [7:0] b);
        return (b[7:1] == GC_ADDR) && !b[0];
    endfunction : is_gc

    // address byte answered by this slave
    function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] own,
                                      input logic aa, input logic gce);
        return aa && ((b[7:1] == own) || (is_gc(b) && gce));
    endfunction : addr_hit

    assign addressed = (q.state == S_RX) || (q.state == S_RX_ACK) ||
                       (q.state == S_TX) || (q.state == S_TX_ACK);

    always_comb
    begin
        next_q = q;
        next_q.mstart = 1'b0;
        if ((lk.stop || lk.start) && addressed)
        begin
            next_q.status = ST_A0;
            next_q.si = 1'b1;
            next_q.sda_low = 1'b0;
            next_q.restart = lk.start;
            next_q.state = S_HOLD;
        end
        else if (lk.start && (q.state != S_HOLD))
        begin
            next_q.state = S_ADDR;
            next_q.cnt = 4'h0;
            next_q.sda_low = 1'b0;
        end
        else if (lk.stop && (q.state != S_HOLD))
        begin
            next_q.state = S_IDLE;
            next_q.sda_low = 1'b0;
        end
        else
        begin
            case (q.state)
                S_IDLE:
                begin
                    if (q.start_pend && !lk.busy)
                    begin
                        next_q.mstart = 1'b1;
                        next_q.start_pend = 1'b0;
                    end
                end
                S_ADDR, S_RX:
                begin
                    if (lk.rise && (q.cnt < BYTE_BITS))
                    begin
                        next_q.sh = {q.sh[6:0], lk.sda};
                        next_q.cnt = q.cnt + 4'h1;
                    end
                    else if (lk.fall && (q.cnt == BYTE_BITS))
                    begin
                        if (q.state == S_RX)
                        begin
                            next_q.rx_byte = q.sh;
                            next_q.sda_low = q.ack_plan;
                            next_q.state = S_RX_ACK;
                        end
                        else if (addr_hit(q.sh, own_bus_addr_i, ack_assert_i, gc_enable_i))
                        begin
                            next_q.sda_low = 1'b1;
                            next_q.state = S_ADDR_ACK;
                            if (q.sh[0])
                            begin
                                next_q.role = ROLE_TX;
                            end
                            else if (is_gc(q.sh))
                            begin
                                next_q.role = ROLE_RX_GC;
                            end
                            else
                            begin
                                next_q.role = ROLE_RX_OWN;
                            end
                        end
                        else
                        begin
                            next_q.state = S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK:
                begin
                    if (lk.fall)
                    begin
                        next_q.sda_low = 1'b0;
                        next_q.si = 1'b1;
                        next_q.state = S_HOLD;
                        case (q.role)
                            ROLE_TX: next_q.status = arb_lost_i ? ST_B0 : ST_A8;
                            ROLE_RX_GC: next_q.status = arb_lost_i ? ST_78 : ST_70;
                            default: next_q.status = arb_lost_i ? ST_68 : ST_60;
                        endcase
                    end
                end
                S_RX_ACK:
                begin
                    if (lk.fall)
                    begin
                        next_q.sda_low = 1'b0;
                        next_q.si = 1'b1;
                        next_q.state = S_HOLD;
                        if (q.role == ROLE_RX_GC)
                        begin
                            next_q.status = q.ack_plan ? ST_90 : ST_98;
                        end
                        else
                        begin
                            next_q.status = q.ack_plan ? ST_80 : ST_88;
                        end
                    end
                end
                S_TX:
                begin
                    if (lk.fall)
                    begin
                        if (q.cnt == LAST_TX_FALL)
                        begin
                            next_q.sda_low = 1'b0;
                            next_q.state = S_TX_ACK;
                        end
                        else
                        begin
                            next_q.sh = {q.sh[6:0], 1'b1};
                            next_q.sda_low = !q.sh[6];
                            next_q.cnt = q.cnt + 4'h1;
                        end
                    end
                end
                S_TX_ACK:
                begin
                    if (lk.rise)
                    begin
                        next_q.nack = lk.sda;
                    end
                    else if (lk.fall)
                    begin
                        next_q.si = 1'b1;
                        next_q.state = S_HOLD;
                        if (q.nack)
                        begin
                            next_q.status = ST_C0;
                        end
                        else
                        begin
                            next_q.status = q.last ? ST_C8 : ST_B8;
                        end
                    end
                end
                S_HOLD:
                begin
                    if (si_clear_i)
                    begin
                        next_q.si = 1'b0;
                        next_q.cnt = 4'h0;
                        case (q.status)
                            ST_A8, ST_B0, ST_B8:
                            begin
                                next_q.sh = byte_buffer_i;
                                next_q.sda_low = !byte_buffer_i[7];
                                next_q.last = !ack_assert_i;
                                next_q.state = S_TX;
                            end
                            ST_60, ST_68, ST_70, ST_78, ST_80, ST_90:
                            begin
                                next_q.ack_plan = ack_assert_i;
                                next_q.state = S_RX;
                            end
                            default:
                            begin
                                next_q.sda_low = 1'b0;
                                next_q.state = q.restart ? S_ADDR : S_IDLE;
                                next_q.restart = 1'b0;
                                next_q.start_pend = begin_request_bit_i;
                            end
                        endcase
                    end
                end
                default:
                begin
                    next_q.state = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q <= '{state: S_IDLE, role: ROLE_RX_OWN, status: ST_NONE, default: '0};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n_o = (q.state != S_HOLD);
    assign sda_oe_n_o = !q.sda_low;
    assign byte_buffer_o = q.rx_byte;
    assign status_o = q.status;
    assign si_o = q.si;
    assign master_start_o = q.mstart;

    // checks
    gc_nack_code_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_RX_ACK && q.role == ROLE_RX_GC && !q.ack_plan && lk.fall
         && !lk.start && !lk.stop) |=> (si_o && status_o == ST_98))
        else $error("general call nack did not give 0x98");

    stop_while_addr_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ((lk.stop || lk.start) && addressed) |=> (si_o && status_o == ST_A0 && !scl_oe_n_o))
        else $error("stop or restart while addressed missed 0xA0");

    no_ack_ignore_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_ADDR && lk.fall && q.cnt == BYTE_BITS && !ack_assert_i
         && !lk.start && !lk.stop) |=> (q.state == S_IDLE && sda_oe_n_o))
        else $error("address answered while ack bit clear");

    gc_gate_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_ADDR && lk.fall && q.cnt == BYTE_BITS && is_gc(q.sh)
         && !gc_enable_i && own_bus_addr_i != GC_ADDR && !lk.start && !lk.stop)
        |=> (q.state == S_IDLE))
        else $error("general call taken while disabled");

    own_ack_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_ADDR && lk.fall && q.cnt == BYTE_BITS && ack_assert_i
         && q.sh[7:1] == own_bus_addr_i && !lk.start && !lk.stop)
        |=> (!sda_oe_n_o [*1] ##1 (q.state == S_ADDR_ACK)))
        else $error("own address not acknowledged");

    start_bus_free_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        master_start_o |-> ($past(!lk.busy) && q.state == S_IDLE))
        else $error("start requested on busy bus");

    tx_entry_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_ADDR_ACK && q.role == ROLE_TX && lk.fall && !lk.start && !lk.stop)
        |=> (si_o && status_o == (($past(arb_lost_i)) ? ST_B0 : ST_A8)))
        else $error("read address gave wrong status");

    last_byte_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_TX_ACK && lk.fall && q.last && !q.nack && !lk.start && !lk.stop)
        |=> (status_o == ST_C8 && si_o))
        else $error("last byte did not give 0xC8");

    acked_byte_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_TX_ACK && lk.fall && !q.last && !q.nack && !lk.start && !lk.stop)
        |=> (status_o == ST_B8))
        else $error("acked byte did not give 0xB8");

    released_idle_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (q.state == S_IDLE) |-> (sda_oe_n_o && scl_oe_n_o))
        else $error("line driven while not addressed");

    hold_until_clear_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (si_o && !si_clear_i) |=> (si_o && !scl_oe_n_o))
        else $error("clock released before flag clear");

endmodule : i2cs_slave

`default_nettype wire

// ---- testbench/i2cs_mst.sv ----
// model: behavioural bus master, open drain, 800 ns bit period
// assumes: pull-ups on both lines, resolved levels fed back on scl_i and sda_i
`timescale 1ns/1ns
`default_nettype none

module i2cs_mst (
    // resolved bus levels
    input wire logic scl_i,
    input wire logic sda_i,
    // drives, 1 releases the line
    output logic scl_od_o,
    output logic sda_od_o
);
    initial
    begin
        scl_od_o = 1'b1;
        sda_od_o = 1'b1;
    end

    // release clock, wait out stretching
    task automatic rel_scl;
        scl_od_o = 1'b1;
        while (scl_i !== 1'b1)
            #50;
    endtask : rel_scl

    task automatic clk_bit(input logic b, output logic r);
        sda_od_o = b;
        #300;
        rel_scl();
        #150;
        r = sda_i;
        #150;
        scl_od_o = 1'b0;
        #200;
    endtask : clk_bit

    task automatic start;
        sda_od_o = 1'b1;
        #300;
        rel_scl();
        #400;
        sda_od_o = 1'b0;
        #400;
        scl_od_o = 1'b0;
        #200;
    endtask : start

    task automatic stop;
        sda_od_o = 1'b0;
        #300;
        rel_scl();
        #400;
        sda_od_o = 1'b1;
        #800;
    endtask : stop

    task automatic wr_byte(input logic [7:0] b, output logic nk);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], r);
        clk_bit(1'b1, nk);
    endtask : wr_byte

    task automatic rd_byte(input logic ak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(ak, r);
    endtask : rd_byte
endmodule : i2cs_mst

`default_nettype wire

// ---- testbench/i2c_slave_rx_end_and_tx_mode_bench.sv ----
// testbench: software side, master model, status queue checks
// assumes: i2cs_slave is the top, pull-ups resolve both bus lines
`timescale 1ns/1ns
`default_nettype none

module i2c_slave_rx_end_and_tx_mode_bench
    import i2cs_pkg::*;
;
    logic mclk, nrst, aa, bsr, sic, arb, gce, si, si_q, mst, nk;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
    logic [6:0] own;
    logic [7:0] txb, rxb, st, b0, b1, b2, d;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int num_checks = 0;
    int n_start = 0;
    wire logic scl_w = m_scl & (scl_oe_n | scl_o);
    wire logic sda_w = m_sda & (sda_oe_n | sda_o);

    i2cs_slave i2cs_slave_i (
        .mclk_i(mclk), .nrst_i(nrst),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .own_bus_addr_i(own), .gc_enable_i(gce), .ack_assert_i(aa),
        .begin_request_bit_i(bsr), .si_clear_i(sic), .arb_lost_i(arb),
        .byte_buffer_i(txb), .byte_buffer_o(rxb), .status_o(st),
        .si_o(si), .master_start_o(mst)
    );

    i2cs_mst i2cs_mst_i (
        .scl_i(scl_w), .sda_i(sda_w), .scl_od_o(m_scl), .sda_od_o(m_sda)
    );

    initial
    begin
        mclk = 1'b0;
        forever
            #50 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // oldest noted status against each new flag
    always @(posedge mclk)
    begin
        si_q <= si;
        if (mst === 1'b1)
            n_start <= n_start + 1;
        if (si === 1'b1 && si_q !== 1'b1)
        begin
            if (exp_q.size() == 0)
                check(8'h01, 8'h00, "flag not expected");
            else
                check(st, exp_q.pop_front(), "status");
        end
    end

    // software: note status, wait flag, set bits, clear flag
    task automatic serve(input logic [7:0] e, input logic a, input logic [7:0] b);
        int n;
        exp_q.push_back(e);
        n = 0;
        while (si !== 1'b1 && n < 4000)
        begin
            @(posedge mclk);
            n++;
        end
        repeat (3) @(posedge mclk);
        check({7'h00, si}, 8'h01, "flag stands");
        check({7'h00, scl_oe_n}, 8'h00, "clock held");
        aa <= a;
        txb <= b;
        sic <= 1'b1;
        @(posedge mclk);
        sic <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : serve

    initial
    begin
        #2000000;
        num_errors++;
        stop_test();
    end

    initial
    begin
        nrst = 1'b0;
        aa = 1'b1;
        bsr = 1'b0;
        sic = 1'b0;
        arb = 1'b0;
        gce = 1'b1;
        txb = 8'h00;
        void'($urandom(32'h9611));
        own = 7'h10 + 7'($urandom_range(0, 95));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        b2 = 8'($urandom);
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (6) @(posedge mclk);
        // own read, last byte after ack cleared, then all ones
        fork
            begin
                i2cs_mst_i.start();
                i2cs_mst_i.wr_byte({own, 1'b1}, nk);
                check({7'h00, nk}, 8'h00, "read address ack");
                i2cs_mst_i.rd_byte(1'b0, d);
                check(d, b0, "first byte");
                i2cs_mst_i.rd_byte(1'b0, d);
                check(d, b1, "last byte");
                i2cs_mst_i.rd_byte(1'b0, d);
                check(d, 8'hFF, "released data");
                i2cs_mst_i.stop();
            end
            begin
                serve(ST_A8, 1'b1, b0);
                serve(ST_B8, 1'b0, b1);
                serve(ST_C8, 1'b1, 8'h00);
            end
        join
        check(8'(n_start), 8'h00, "no start request");
        // lost arbitration, read, master nack, start request
        @(posedge mclk);
        arb <= 1'b1;
        bsr <= 1'b1;
        fork
            begin
                i2cs_mst_i.start();
                i2cs_mst_i.wr_byte({own, 1'b1}, nk);
                i2cs_mst_i.rd_byte(1'b1, d);
                check(d, b2, "byte after lost arbitration");
                i2cs_mst_i.stop();
            end
            begin
                serve(ST_B0, 1'b1, b2);
                arb <= 1'b0;
                serve(ST_C0, 1'b1, 8'h00);
                check(8'(n_start), 8'h00, "start while busy");
            end
        join
        repeat (20) @(posedge mclk);
        check(8'(n_start), 8'h01, "start request");
        bsr <= 1'b0;
        // general call byte nacked, ack bit left clear
        b0 = 8'($urandom);
        fork
            begin
                i2cs_mst_i.start();
                i2cs_mst_i.wr_byte({GC_ADDR, 1'b0}, nk);
                check({7'h00, nk}, 8'h00, "general call ack");
                i2cs_mst_i.wr_byte(b0, nk);
                check({7'h00, nk}, 8'h01, "general call byte nack");
                i2cs_mst_i.stop();
            end
            begin
                serve(ST_70, 1'b0, 8'h00);
                serve(ST_98, 1'b0, 8'h00);
            end
        join
        check(rxb, b0, "general call byte");
        i2cs_mst_i.start();
        i2cs_mst_i.wr_byte({own, 1'b1}, nk);
        check({7'h00, nk}, 8'h01, "ignored while ack clear");
        i2cs_mst_i.stop();
        // ack bit set again, write then stop while addressed
        @(posedge mclk);
        aa <= 1'b1;
        fork
            begin
                i2cs_mst_i.start();
                i2cs_mst_i.wr_byte({own, 1'b0}, nk);
                check({7'h00, nk}, 8'h00, "recognised again");
                i2cs_mst_i.stop();
            end
            begin
                serve(ST_60, 1'b1, 8'h00);
                serve(ST_A0, 1'b1, 8'h00);
            end
        join
        // write, repeated start while addressed, then own read
        fork
            begin
                i2cs_mst_i.start();
                i2cs_mst_i.wr_byte({own, 1'b0}, nk);
                i2cs_mst_i.start();
                i2cs_mst_i.wr_byte({own, 1'b1}, nk);
                check({7'h00, nk}, 8'h00, "read after restart");
                i2cs_mst_i.rd_byte(1'b1, d);
                check(d, b1, "byte after restart");
                i2cs_mst_i.stop();
            end
            begin
                serve(ST_60, 1'b1, 8'h00);
                serve(ST_A0, 1'b1, 8'h00);
                serve(ST_A8, 1'b1, b1);
                serve(ST_C0, 1'b1, 8'h00);
            end
        join
        // general call disabled
        @(posedge mclk);
        gce <= 1'b0;
        i2cs_mst_i.start();
        i2cs_mst_i.wr_byte({GC_ADDR, 1'b0}, nk);
        check({7'h00, nk}, 8'h01, "general call disabled");
        i2cs_mst_i.stop();
        check(8'(exp_q.size()), 8'h00, "flags pending");
        stop_test();
    end
endmodule : i2c_slave_rx_end_and_tx_mode_bench

`default_nettype wire
